// >>> rtl/mcp_pkg.sv
// package of constants and carrier types for the motor current protection block
package mcp_pkg;
   // ==========================================================
   // timing
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned TICK_NS         = 1_000_000;   // 1 ms time base
   localparam int unsigned CLK_NS          = 10;
   localparam int unsigned TICK_CYC        = TICK_NS / CLK_NS;
   localparam int unsigned SC_PICKUP_MS    = 50;
   localparam int unsigned SC_RESET_MS     = 50;
   localparam int unsigned UC_PICKUP_MS    = 300;
   localparam int unsigned UC_RESET_MS     = 350;
   localparam int unsigned GF_PICKUP_MS    = 50;
   localparam int unsigned GF_RESET_MS     = 50;
   localparam int unsigned GF_MIN_OP_MS    = 50;
   localparam int unsigned UB_PICKUP_MS    = 100;
   localparam int unsigned UB_RESET_MS     = 200;
   localparam int unsigned PR_OPERATE_MS   = 200;
   localparam int unsigned PR_RESET_MS     = 200;
   localparam int unsigned PR_PICKUP_MS    = 1;
   localparam int unsigned COOL_WRAP       = 3_600_000; // cooling units that make one step
   localparam int unsigned COOL_STEP       = 1000;      // ms removed per cooling step
   localparam int unsigned MS_W            = 20;
   // ==========================================================
   // data widths and fixed figures
   localparam int unsigned CUR_W           = 16;
   localparam int unsigned ACC_W           = 32;
   localparam logic [15:0] DISABLED_READ   = 16'd999;
   localparam int unsigned STOP_PCT        = 12;
   localparam int unsigned PR_PCT          = 75;
   localparam int unsigned PCT_FULL        = 100;
   localparam int unsigned UB_HIGH_MULT    = 4;
   // ==========================================================
   // register bus map (word addresses on a 32-bit avalon slave)
   localparam logic [4:0] A_SELECT   = 5'h00;
   localparam logic [4:0] A_SC_PU    = 5'h01;
   localparam logic [4:0] A_SC_OP    = 5'h02;
   localparam logic [4:0] A_UC_PU    = 5'h03;
   localparam logic [4:0] A_UC_OP    = 5'h04;
   localparam logic [4:0] A_GF_PU    = 5'h05;
   localparam logic [4:0] A_GF_OP    = 5'h06;
   localparam logic [4:0] A_UB_PU    = 5'h07;
   localparam logic [4:0] A_UB_TC    = 5'h08;
   localparam logic [4:0] A_FLA      = 5'h09;
   localparam logic [4:0] A_SU_LIMIT = 5'h0A;
   localparam logic [4:0] A_SU_COOL  = 5'h0B;
   localparam logic [4:0] A_SU_ACC   = 5'h0C;
   localparam logic [4:0] A_STATUS   = 5'h0D;
   // select bits
   localparam int unsigned B_SC_EN   = 0;
   localparam int unsigned B_UC_EN   = 1;
   localparam int unsigned B_GF_EN   = 2;
   localparam int unsigned B_UB_EN   = 3;
   localparam int unsigned B_PR_EN   = 4;
   localparam int unsigned B_SC_DBL  = 5;
   localparam int unsigned B_GFD_LO  = 8;   // 2-bit ground disable field
   localparam logic [1:0] GFD_OFF = 2'h0;
   localparam logic [1:0] GFD_X4  = 2'h1;
   localparam logic [1:0] GFD_X6  = 2'h2;
   localparam logic [1:0] GFD_X8  = 2'h3;
   localparam logic [31:0] SELECT_RST = 32'h0000_001F;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [CUR_W-1:0] ia;
      logic [CUR_W-1:0] ib;
      logic [CUR_W-1:0] ic;
      logic [CUR_W-1:0] ignd;
      logic [CUR_W-1:0] ineg;
   } mcp_meas_t;

   typedef struct packed {
      logic sc;
      logic uc;
      logic gf;
      logic ub;
      logic pr;
   } mcp_elem_t;
endpackage

// >>> rtl/mcp_timer.sv
// pickup / operate / reset timing stage shared by every element
`timescale 1ns/1ps
module mcp_timer #(
   parameter int unsigned W = 32
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         tick,
   // condition and settings
   input  wire logic         cond,
   input  wire logic         enable,
   input  wire logic [19:0]  pickup_ms,
   input  wire logic [19:0]  reset_ms,
   input  wire logic [W-1:0] op_ms,
   // results
   output logic              picked_q,
   output logic              trip_q
);
   logic [19:0]  pu_cnt_q;
   logic [19:0]  rs_cnt_q;
   logic [W-1:0] op_cnt_q;

   // pickup delay while condition holds, reset delay once it drops
   always_ff @(posedge clk_sys) begin
      if (rst || !enable) begin
         pu_cnt_q <= '0;
         rs_cnt_q <= '0;
         picked_q <= 1'b0;
      end else if (tick) begin
         if (cond) begin
            rs_cnt_q <= '0;
            if (!picked_q) begin
               if (pu_cnt_q + 20'd1 >= pickup_ms) picked_q <= 1'b1;
               else pu_cnt_q <= pu_cnt_q + 20'd1;
            end
         end else begin
            pu_cnt_q <= '0;
            if (picked_q) begin
               if (rs_cnt_q + 20'd1 >= reset_ms) begin
                  picked_q <= 1'b0;
                  rs_cnt_q <= '0;
               end else rs_cnt_q <= rs_cnt_q + 20'd1;
            end
         end
      end
   end

   // operate timer runs while picked, restarts from zero on release
   always_ff @(posedge clk_sys) begin
      if (rst || !enable || !picked_q) begin
         op_cnt_q <= '0;
         trip_q   <= 1'b0;
      end else if (tick && !trip_q) begin
         if (op_cnt_q + W'(1) >= op_ms) trip_q <= 1'b1;
         else op_cnt_q <= op_cnt_q + W'(1);
      end
   end
endmodule // mcp_timer

// >>> rtl/mcp_protect.sv
// motor current protection elements with avalon-mm settings registers
// ==========================================================
// What this block does
// - short-circuit picks up 50 ms after any phase over setting, trips after delay
// - short-circuit releases 50 ms after all phases fall below setting
// - doubling option doubles short-circuit threshold during start-up
// - block input suppresses trip, timing continues
// - disabled element gives no pickup or trip, setting reads 999
// - start-up hides pickup of short-circuit, undercurrent, ground, unbalance
// - undercurrent picks up 300 ms after all phases below setting, then trips
// - undercurrent inhibited when all phases below 12 percent full load
// - undercurrent resets 350 ms after any phase rises above setting
// - ground fault picks up after 50 ms, trips after delay of at least 50 ms
// - ground fault resets 50 ms after current drops below setting
// - ground fault optionally disabled above four, six or eight times full load
// - unbalance picks up 100 ms after negative sequence exceeds setting
// - unbalance time is constant over squared current minus squared setting
// - unbalance resets 200 ms after current drops below setting
// - unbalance inhibited below 12 percent or above four times full load
// - unbalance blocked while phase reversal trips
// - phase reversal trips 200 ms after negative sequence over 75 percent max
// - phase reversal clears 200 ms after falling below 75 percent
// - start-up time accumulates, restart disabled while above limit
// - accumulator counts down continuously, also during start-up
// - emergency start permits start despite accumulator above limit
`timescale 1ns/1ps
module mcp_protect #(
   parameter int unsigned TICK_CYCLES = mcp_pkg::TICK_CYC
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst,
   // avalon-mm slave
   input  wire logic [4:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   // measurements and controls
   input  wire mcp_pkg::mcp_meas_t meas,
   input  wire logic              startup,
   input  wire mcp_pkg::mcp_elem_t block_in,
   input  wire logic              emerg_start,
   // results
   output mcp_pkg::mcp_elem_t     pickup_q,
   output mcp_pkg::mcp_elem_t     trip_q,
   output logic                   restart_disable_q
);
   localparam int unsigned CW = mcp_pkg::CUR_W;
   localparam int unsigned AW = mcp_pkg::ACC_W;

   // ==========================================================
   // millisecond tick
   logic [31:0] div_q;
   logic        tick;
   always_ff @(posedge clk_sys) begin
      if (rst || tick) div_q <= '0;
      else div_q <= div_q + 32'd1;
   end
   assign tick = (div_q == 32'(TICK_CYCLES - 1));

   // ==========================================================
   // settings registers
   logic [31:0]   select_q;
   logic [CW-1:0] sc_pu_q, uc_pu_q, gf_pu_q, ub_pu_q, fla_q;
   logic [AW-1:0] sc_op_q, uc_op_q, gf_op_q, ub_tc_q, su_limit_q, su_cool_q;
   logic [AW-1:0] su_acc_q;
   logic          ack_q;
   logic          wr_acc;

   // one wait cycle, answer on the second edge
   always_ff @(posedge clk_sys) begin
      if (rst) ack_q <= 1'b0;
      else ack_q <= (avs_read || avs_write) && !ack_q;
   end
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign wr_acc = avs_write && ack_q;

   // settings writes
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         select_q   <= mcp_pkg::SELECT_RST;
         sc_pu_q    <= '1;
         uc_pu_q    <= '0;
         gf_pu_q    <= '1;
         ub_pu_q    <= '1;
         fla_q      <= '0;
         sc_op_q    <= AW'(mcp_pkg::GF_MIN_OP_MS);
         uc_op_q    <= AW'(mcp_pkg::GF_MIN_OP_MS);
         gf_op_q    <= AW'(mcp_pkg::GF_MIN_OP_MS);
         ub_tc_q    <= '0;
         su_limit_q <= '1;
         su_cool_q  <= '0;
      end else if (wr_acc) begin
         case (avs_address)
            mcp_pkg::A_SELECT:   select_q   <= avs_writedata;
            mcp_pkg::A_SC_PU:    sc_pu_q    <= avs_writedata[CW-1:0];
            mcp_pkg::A_SC_OP:    sc_op_q    <= avs_writedata;
            mcp_pkg::A_UC_PU:    uc_pu_q    <= avs_writedata[CW-1:0];
            mcp_pkg::A_UC_OP:    uc_op_q    <= avs_writedata;
            mcp_pkg::A_GF_PU:    gf_pu_q    <= avs_writedata[CW-1:0];
            mcp_pkg::A_GF_OP:    gf_op_q    <= (avs_writedata < AW'(mcp_pkg::GF_MIN_OP_MS)) ?
                                               AW'(mcp_pkg::GF_MIN_OP_MS) : avs_writedata;
            mcp_pkg::A_UB_PU:    ub_pu_q    <= avs_writedata[CW-1:0];
            mcp_pkg::A_UB_TC:    ub_tc_q    <= avs_writedata;
            mcp_pkg::A_FLA:      fla_q      <= avs_writedata[CW-1:0];
            mcp_pkg::A_SU_LIMIT: su_limit_q <= avs_writedata;
            mcp_pkg::A_SU_COOL:  su_cool_q  <= avs_writedata;
            default: ;
         endcase
      end
   end

   // pickup setting read value, 999 while the element is disabled
   function automatic logic [31:0] pu_read(input logic en, input logic [CW-1:0] v);
      pu_read = en ? 32'(v) : 32'(mcp_pkg::DISABLED_READ);
   endfunction

   // read mux, registered answer
   always_ff @(posedge clk_sys) begin
      if (rst) avs_readdata <= '0;
      else if (avs_read && !ack_q) begin
         case (avs_address)
            mcp_pkg::A_SELECT:   avs_readdata <= select_q;
            mcp_pkg::A_SC_PU:    avs_readdata <= pu_read(select_q[mcp_pkg::B_SC_EN], sc_pu_q);
            mcp_pkg::A_SC_OP:    avs_readdata <= sc_op_q;
            mcp_pkg::A_UC_PU:    avs_readdata <= pu_read(select_q[mcp_pkg::B_UC_EN], uc_pu_q);
            mcp_pkg::A_UC_OP:    avs_readdata <= uc_op_q;
            mcp_pkg::A_GF_PU:    avs_readdata <= pu_read(select_q[mcp_pkg::B_GF_EN], gf_pu_q);
            mcp_pkg::A_GF_OP:    avs_readdata <= gf_op_q;
            mcp_pkg::A_UB_PU:    avs_readdata <= pu_read(select_q[mcp_pkg::B_UB_EN], ub_pu_q);
            mcp_pkg::A_UB_TC:    avs_readdata <= ub_tc_q;
            mcp_pkg::A_FLA:      avs_readdata <= 32'(fla_q);
            mcp_pkg::A_SU_LIMIT: avs_readdata <= su_limit_q;
            mcp_pkg::A_SU_COOL:  avs_readdata <= su_cool_q;
            mcp_pkg::A_SU_ACC:   avs_readdata <= su_acc_q;
            mcp_pkg::A_STATUS:   avs_readdata <= {21'h0, restart_disable_q, pickup_q, trip_q};
            default:             avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // level detection (all products kept wide)
   logic [CW-1:0] imax;
   logic [CW+7:0] fla_ext, imax_ext, stop_lvl, ineg_pct, imax_pct;
   logic          any_over_sc, all_under_uc, all_stopped, any_above;
   logic [CW:0]   sc_thr;
   logic          gf_hi_off, ub_inhibit, pr_cond;
   always_comb begin
      imax = meas.ia;
      if (meas.ib > imax) imax = meas.ib;
      if (meas.ic > imax) imax = meas.ic;
      fla_ext  = (CW+8)'(fla_q);
      imax_ext = (CW+8)'(imax);
      stop_lvl = (CW+8)'(fla_ext * (CW+8)'(mcp_pkg::STOP_PCT));
      // doubled threshold during start-up
      sc_thr = (select_q[mcp_pkg::B_SC_DBL] && startup) ?
               {sc_pu_q, 1'b0} : {1'b0, sc_pu_q};
      any_over_sc  = ((CW+1)'(imax) > sc_thr);
      all_under_uc = (imax < uc_pu_q);
      all_stopped  = (imax_ext * (CW+8)'(mcp_pkg::PCT_FULL)) < stop_lvl;
      // ground fault high-current disable
      case (select_q[mcp_pkg::B_GFD_LO +: 2])
         mcp_pkg::GFD_X4: any_above = imax_ext > (fla_ext << 2);
         mcp_pkg::GFD_X6: any_above = imax_ext > ((fla_ext << 2) + (fla_ext << 1));
         mcp_pkg::GFD_X8: any_above = imax_ext > (fla_ext << 3);
         default:         any_above = 1'b0;
      endcase
      gf_hi_off = any_above;
      ub_inhibit = all_stopped ||
                   (imax_ext > (CW+8)'(fla_ext * (CW+8)'(mcp_pkg::UB_HIGH_MULT)));
      ineg_pct = (CW+8)'((CW+8)'(meas.ineg) * (CW+8)'(mcp_pkg::PCT_FULL));
      imax_pct = (CW+8)'(imax_ext * (CW+8)'(mcp_pkg::PR_PCT));
      pr_cond  = ineg_pct > imax_pct;
   end

   // ==========================================================
   // unbalance inverse time: tc / (i2^2 - pu^2), recomputed by a divider
   // the result trails a change of current by up to two division passes, since ub_den is not held during a pass
   logic [AW-1:0] ub_den, ub_op_q, quo_q, rem_q;
   logic [5:0]    bit_q;
   logic          div_busy_q;
   assign ub_den = AW'(meas.ineg) * AW'(meas.ineg) - AW'(ub_pu_q) * AW'(ub_pu_q);
   logic [AW:0] rem_sh;
   assign rem_sh = {rem_q, ub_tc_q[bit_q[4:0]]};
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_busy_q <= 1'b0;
         bit_q      <= '0;
         quo_q      <= '0;
         rem_q      <= '0;
         ub_op_q    <= '1;
      end else if (!div_busy_q) begin
         div_busy_q <= 1'b1;
         bit_q      <= 6'(AW - 1);
         quo_q      <= '0;
         rem_q      <= '0;
      end else begin
         if (ub_den != '0 && rem_sh >= {1'b0, ub_den}) begin
            rem_q <= AW'(rem_sh - {1'b0, ub_den});
            quo_q <= {quo_q[AW-2:0], 1'b1};
         end else begin
            rem_q <= rem_sh[AW-1:0];
            quo_q <= {quo_q[AW-2:0], 1'b0};
         end
         if (bit_q == '0) begin
            div_busy_q <= 1'b0;
            ub_op_q <= (ub_den == '0) ? '1 : {quo_q[AW-2:0], (rem_sh >= {1'b0, ub_den})};
         end else bit_q <= bit_q - 6'd1;
      end
   end

   // ==========================================================
   // element timers
   localparam int unsigned NE = 5;
   logic [NE-1:0] cond, en, picked, tripped;
   logic [AW-1:0] op_ms [NE];
   logic [19:0]   pu_ms [NE];
   logic [19:0]   rs_ms [NE];
   always_comb begin
      // order: sc, uc, gf, ub, pr
      cond = {any_over_sc, all_under_uc,
              meas.ignd > gf_pu_q, meas.ineg > ub_pu_q, pr_cond};
      // stopped motor takes undercurrent out of operation at once,
      // so no reset delay keeps a stale pickup alive
      en = {select_q[mcp_pkg::B_SC_EN], select_q[mcp_pkg::B_UC_EN] && !all_stopped,
            select_q[mcp_pkg::B_GF_EN] && !gf_hi_off,
            select_q[mcp_pkg::B_UB_EN] && !ub_inhibit && !trip_q.pr,
            select_q[mcp_pkg::B_PR_EN]};
      op_ms[4] = sc_op_q;
      op_ms[3] = uc_op_q;
      op_ms[2] = gf_op_q;
      op_ms[1] = ub_op_q;
      op_ms[0] = AW'(mcp_pkg::PR_OPERATE_MS);
      pu_ms[4] = 20'(mcp_pkg::SC_PICKUP_MS);
      pu_ms[3] = 20'(mcp_pkg::UC_PICKUP_MS);
      pu_ms[2] = 20'(mcp_pkg::GF_PICKUP_MS);
      pu_ms[1] = 20'(mcp_pkg::UB_PICKUP_MS);
      pu_ms[0] = 20'(mcp_pkg::PR_PICKUP_MS);
      rs_ms[4] = 20'(mcp_pkg::SC_RESET_MS);
      rs_ms[3] = 20'(mcp_pkg::UC_RESET_MS);
      rs_ms[2] = 20'(mcp_pkg::GF_RESET_MS);
      rs_ms[1] = 20'(mcp_pkg::UB_RESET_MS);
      rs_ms[0] = 20'(mcp_pkg::PR_RESET_MS);
   end

   genvar g;
   generate
      for (g = 0; g < NE; g++) begin : g_el
         mcp_timer #(.W(AW)) u_tmr (
            .clk_sys  (clk_sys),
            .rst      (rst),
            .tick     (tick),
            .cond     (cond[g]),
            .enable   (en[g]),
            .pickup_ms(pu_ms[g]),
            .reset_ms (rs_ms[g]),
            .op_ms    (op_ms[g]),
            .picked_q (picked[g]),
            .trip_q   (tripped[g])
         );
      end
   endgenerate

   // registered outputs: block masks trip, start-up masks pickup of sc, uc, gf, ub; pr pickup is always masked
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pickup_q <= '0;
         trip_q   <= '0;
      end else begin
         pickup_q <= mcp_pkg::mcp_elem_t'(picked & ~{{4{startup}}, 1'b1});
         trip_q   <= mcp_pkg::mcp_elem_t'(tripped & ~block_in);
      end
   end

   // ==========================================================
   // cumulative start-up time counter
   logic [AW-1:0] cool_acc_q;
   logic [AW-1:0] su_add, su_sub, cool_sum;
   logic          cool_wrap;
   // one ms in per ms of start-up, one cooling step out per wrap
   always_comb begin
      su_add    = startup ? AW'(1) : '0;
      cool_sum  = cool_acc_q + su_cool_q;
      cool_wrap = (cool_sum >= AW'(mcp_pkg::COOL_WRAP));
      su_sub    = cool_wrap ? AW'(mcp_pkg::COOL_STEP) : '0;
   end

   // accumulator floors at zero, cooling also runs during a start-up
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         su_acc_q   <= '0;
         cool_acc_q <= '0;
      end else if (tick) begin
         if (cool_wrap) cool_acc_q <= cool_sum - AW'(mcp_pkg::COOL_WRAP);
         else cool_acc_q <= cool_sum;
         if (su_acc_q + su_add < su_sub) su_acc_q <= '0;
         else su_acc_q <= su_acc_q + su_add - su_sub;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) restart_disable_q <= 1'b0;
      else restart_disable_q <= (su_acc_q > su_limit_q) && !emerg_start;
   end

   // ==========================================================
   // checks
   restart_emerg_a: assert property (@(posedge clk_sys) disable iff (rst)
      emerg_start |=> !restart_disable_q) else $error("restart disable during emergency start");
   trip_block_a: assert property (@(posedge clk_sys) disable iff (rst)
      block_in.sc |=> !trip_q.sc) else $error("short-circuit trip not blocked");
   block_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
      (block_in != '0) |=> ((trip_q & $past(block_in)) == '0))
      else $error("blocked trip shown");
   startup_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
      startup |=> !pickup_q.sc && !pickup_q.uc && !pickup_q.gf && !pickup_q.ub)
      else $error("pickup shown in start-up");
   ub_pr_block_a: assert property (@(posedge clk_sys) disable iff (rst)
      trip_q.pr |=> ##1 !picked[1]) else $error("unbalance active during reversal");
   ub_inhibit_a: assert property (@(posedge clk_sys) disable iff (rst)
      ub_inhibit |=> !picked[1]) else $error("unbalance active while inhibited");
   gf_hi_off_a: assert property (@(posedge clk_sys) disable iff (rst)
      gf_hi_off |=> !picked[2]) else $error("ground fault active above current limit");
   disabled_sc_a: assert property (@(posedge clk_sys) disable iff (rst)
      !select_q[mcp_pkg::B_SC_EN] |=> ##1 !trip_q.sc) else $error("disabled element trips");
   disabled_gf_a: assert property (@(posedge clk_sys) disable iff (rst)
      !select_q[mcp_pkg::B_GF_EN] |=> ##1 !trip_q.gf) else $error("disabled ground trips");
   gf_min_op_a: assert property (@(posedge clk_sys) disable iff (rst)
      gf_op_q >= AW'(mcp_pkg::GF_MIN_OP_MS)) else $error("ground operate below minimum");
   tick_period_a: assert property (@(posedge clk_sys) disable iff (rst)
      tick |=> !tick) else $error("tick too frequent");
   stop_uc_a: assert property (@(posedge clk_sys) disable iff (rst)
      all_stopped |=> !picked[3]) else $error("undercurrent active on stopped motor");
   // main scenarios reached
   cv_sc_trip: cover property (@(posedge clk_sys) trip_q.sc);
   cv_gf_trip: cover property (@(posedge clk_sys) trip_q.gf);
   cv_ub_trip: cover property (@(posedge clk_sys) trip_q.ub);
   cv_pr_trip: cover property (@(posedge clk_sys) trip_q.pr);
   cv_restart: cover property (@(posedge clk_sys) restart_disable_q);
endmodule // mcp_protect

// >>> test/mcp_protect_test.sv
// self-checking bench for the motor current protection block
`timescale 1ns/1ps
module mcp_protect_test;
   // ==========================================================
   // signals
   logic               clk_sys = 1'b0;
   logic               rst = 1'b1;
   logic [4:0]         avs_address = 5'h00;
   logic               avs_read = 1'b0;
   logic               avs_write = 1'b0;
   logic [31:0]        avs_writedata = 32'h0;
   logic [31:0]        avs_readdata;
   logic               avs_waitrequest;
   mcp_pkg::mcp_meas_t meas = '0;
   logic               startup = 1'b0;
   mcp_pkg::mcp_elem_t block_in = '0;
   logic               emerg_start = 1'b0;
   mcp_pkg::mcp_elem_t pickup_q;
   mcp_pkg::mcp_elem_t trip_q;
   logic               restart_disable_q;
   int                 error_cnt = 0;
   int                 cmp_count = 0;
   int                 cyc = 0;
   logic [31:0]        rd;

   // clock, 10 ns period
   always #5 clk_sys = ~clk_sys;

   mcp_protect #(.TICK_CYCLES(10)) u_dut (
      .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .meas(meas), .startup(startup),
      .block_in(block_in), .emerg_start(emerg_start), .pickup_q(pickup_q),
      .trip_q(trip_q), .restart_disable_q(restart_disable_q)
   );

   // ==========================================================
   // tasks
   task automatic final_report();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // avalon access: hold request until waitrequest is sampled low
   task automatic av_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= ~wr;
      avs_write     <= wr;
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      av_xfer(1'b1, a, d);
   endtask

   task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
      av_xfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // one ms is ten clock cycles with the shortened tick
   task automatic ms(input int m);
      repeat (m * 10) @(posedge clk_sys);
   endtask

   // hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         final_report();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      rdc(mcp_pkg::A_SELECT, 32'h0000_001F);
      rdc(5'h1F, 32'h0);
      wr(mcp_pkg::A_FLA, 32'h64);
      wr(mcp_pkg::A_SC_PU, 32'h1F4);
      wr(mcp_pkg::A_SC_OP, 32'h32);
      wr(mcp_pkg::A_GF_PU, 32'h32);
      wr(mcp_pkg::A_GF_OP, 32'hA);
      wr(mcp_pkg::A_UC_OP, 32'h14);
      wr(mcp_pkg::A_SU_LIMIT, 32'h64);
      wr(mcp_pkg::A_SU_COOL, 32'h0);
      meas.ia <= 16'h64; meas.ib <= 16'h64; meas.ic <= 16'h64;
      ms(5);
      // short circuit pickup, trip, block and release
      meas.ia <= 16'h258;
      ms(40); chk(pickup_q.sc, 1'b0);
      ms(20); chk(pickup_q.sc, 1'b1);
      chk(trip_q.sc, 1'b0);
      ms(50); chk(trip_q.sc, 1'b1);
      block_in.sc <= 1'b1;
      ms(2); chk(trip_q.sc, 1'b0);
      chk(pickup_q.sc, 1'b1);
      block_in.sc <= 1'b0;
      meas.ia <= 16'h64;
      ms(40); chk(pickup_q.sc, 1'b1);
      ms(20); chk(pickup_q.sc, 1'b0);
      chk(trip_q.sc, 1'b0);
      // doubling during start-up, start-up time counting
      wr(mcp_pkg::A_SELECT, 32'h3F);
      startup <= 1'b1;
      meas.ia <= 16'h320;
      ms(150); chk(pickup_q.sc, 1'b0);
      chk(trip_q.sc, 1'b0);
      startup <= 1'b0;
      ms(60); chk(pickup_q.sc, 1'b1);
      chk(restart_disable_q, 1'b1);
      av_xfer(1'b0, mcp_pkg::A_SU_ACC, 32'h0);
      chk(rd > 32'h64 && rd <= 32'h96, 1'b1);
      emerg_start <= 1'b1;
      ms(1); chk(restart_disable_q, 1'b0);
      emerg_start <= 1'b0;
      // countdown runs on during a start-up
      startup <= 1'b1;
      wr(mcp_pkg::A_SU_COOL, 32'h0036_EE80);
      ms(5); rdc(mcp_pkg::A_SU_ACC, 32'h0);
      chk(restart_disable_q, 1'b0);
      startup <= 1'b0;
      wr(mcp_pkg::A_SU_COOL, 32'h0);
      meas.ia <= 16'h64;
      ms(60);
      // disabled short circuit element
      wr(mcp_pkg::A_SELECT, 32'h1E);
      rdc(mcp_pkg::A_SC_PU, 32'd999);
      meas.ia <= 16'h320;
      ms(120); chk(pickup_q.sc | trip_q.sc, 1'b0);
      meas.ia <= 16'h64;
      wr(mcp_pkg::A_SELECT, 32'h1F);
      // ground fault with clamped operate time
      meas.ignd <= 16'h64;
      ms(40); chk(pickup_q.gf, 1'b0);
      ms(20); chk(pickup_q.gf, 1'b1);
      ms(30); chk(trip_q.gf, 1'b0);
      ms(20); chk(trip_q.gf, 1'b1);
      meas.ignd <= 16'h0;
      ms(40); chk(trip_q.gf, 1'b1);
      ms(20); chk(trip_q.gf, 1'b0);
      wr(mcp_pkg::A_SELECT, 32'h11F);
      meas.ia <= 16'h1C2;
      meas.ignd <= 16'h64;
      ms(120); chk(pickup_q.gf | trip_q.gf, 1'b0);
      meas.ignd <= 16'h0;
      meas.ia <= 16'h64;
      wr(mcp_pkg::A_SELECT, 32'h1F);
      // phase reversal
      meas.ineg <= 16'h50;
      ms(180); chk(trip_q.pr, 1'b0);
      ms(40); chk(trip_q.pr, 1'b1);
      chk(pickup_q.pr, 1'b0);
      meas.ineg <= 16'h0;
      ms(180); chk(trip_q.pr, 1'b1);
      ms(40); chk(trip_q.pr, 1'b0);
      // unbalance pickup, inverse time, reset, reversal block, inhibit
      wr(mcp_pkg::A_UB_PU, 32'h14);
      wr(mcp_pkg::A_UB_TC, 32'h1D4C0);
      meas.ineg <= 16'h28;
      ms(90); chk(pickup_q.ub, 1'b0);
      ms(20); chk(pickup_q.ub, 1'b1);
      ms(80); chk(trip_q.ub, 1'b0);
      ms(20); chk(trip_q.ub, 1'b1);
      meas.ineg <= 16'h0;
      ms(180); chk(pickup_q.ub, 1'b1);
      ms(40); chk(pickup_q.ub | trip_q.ub, 1'b0);
      meas.ineg <= 16'h50;
      ms(220); chk(trip_q.pr, 1'b1);
      chk(pickup_q.ub | trip_q.ub, 1'b0);
      meas.ineg <= 16'h0;
      ms(220); chk(trip_q.pr, 1'b0);
      meas.ia <= 16'h1C2;
      meas.ineg <= 16'h28;
      ms(120); chk(pickup_q.ub | trip_q.ub, 1'b0);
      meas.ineg <= 16'h0;
      meas.ia <= 16'h64;
      // undercurrent pickup, trip, reset, stopped motor
      wr(mcp_pkg::A_UC_PU, 32'h32);
      meas.ia <= 16'h1E; meas.ib <= 16'h1E; meas.ic <= 16'h1E;
      ms(280); chk(pickup_q.uc, 1'b0);
      ms(40); chk(pickup_q.uc, 1'b1);
      ms(40); chk(trip_q.uc, 1'b1);
      meas.ia <= 16'h64;
      ms(330); chk(pickup_q.uc, 1'b1);
      ms(40); chk(pickup_q.uc, 1'b0);
      meas.ia <= 16'hA; meas.ib <= 16'hA; meas.ic <= 16'hA;
      ms(400); chk(pickup_q.uc | trip_q.uc, 1'b0);
      final_report();
   end
endmodule // mcp_protect_test
